// ===== src/ss_consts.svh
// Offsets, field positions, codes and limits of the SS decode sequencer.
// Assumes an 8-bit APB byte address and one word per register.
`ifndef SS_CONSTS_SVH
`define SS_CONSTS_SVH
// Register byte offsets
`define OFF_CTRL 8'h00
`define OFF_INSTR 8'h04
`define OFF_FIELDS 8'h08
`define OFF_GRWR 8'h0C
`define OFF_STATUS 8'h10
`define OFF_OP1 8'h14
`define OFF_OP2 8'h18
`define OFF_FAULT 8'h1C
// Control and general register write fields
`define CTRL_START 0
`define CTRL_SIZE_LO 1
`define CTRL_SIZE_HI 2
`define GRWR_IDX_LO 16
`define GRWR_IDX_HI 18
// Reset values
`define SIZE_RST 2'h0
`define IADDR_RST 16'h0000
// Auxiliary storage positions
`define AUX_OP 7'h00
`define AUX_BYTE2 7'h01
`define AUX_SCRATCH 7'h07
`define AUX_NEXT 7'h30
`define AUX_OP1 7'h40
// Storage size limits on the high address nibble
`define LIM_4K 4'h0
`define LIM_8K 4'h1
`define LIM_16K 4'h2
// Lowest unprotected address
`define PROT_LIMIT 16'h0090
// Stop codes
`define STOP_OPCODE 4'h1
`define STOP_PROTECT 4'h4
`define STOP_ADDRESS 4'h5
// Upper op-code nibbles
`define UP_DEC 4'hF
`define UP_BAD_E 4'hE
`define UP_LOW 4'hD
`define UP_BAD_C 4'hC
// Indicator values
`define IND_LENGTHS 4'h8
`define IND_MULDIV 4'h0
// Instruction length in bytes
`define INSTR_LEN 16'h0006
`endif

// ===== src/seq_pkg.sv
// Types shared by the SS decode sequencer.
// Assumes the constants header is compiled alongside.
package seq_pkg;
	typedef enum logic [4:0] {
		st_idle, st_op1, st_chk1, st_op2, st_chk2, st_oprd, st_udec,
		st_fprot, st_flow, st_len2, st_clr, st_md, st_len1, st_ffin,
		st_dtio, st_dp2, st_dp1, st_dfin, st_exec, st_halt
	} seq_state_t;

	typedef struct packed {
		seq_state_t st;
		logic [7:0] op;
		logic [7:0] byte2;
		logic [15:0] iaddr;
		logic [15:0] first_field;
		logic [15:0] second_field;
		logic [1:0] size;
		logic [15:0] addr1;
		logic [15:0] addr2;
		logic [15:0] units1;
		logic [15:0] units2;
		logic [15:0] fault;
		logic [3:0] upper_nibble_latch;
		logic [3:0] lower_nibble_latch;
		logic [3:0] high_nibble_register;
		logic [3:0] stop_code_indicator;
		logic [7:0] exec_code;
		logic start;
		logic [2:0] rsync;
		logic [31:0] rdata;
	} seq_regs_t;

	typedef struct packed {
		logic [7:0][15:0] r;
	} gen_regs_t;

	typedef struct packed {
		logic [127:0][7:0] m;
	} aux_regs_t;
endpackage : seq_pkg

// ===== src/gen_regs.sv
// Eight 16-bit general registers used for operand indexing.
// Assumes one writer and one combinational reader on pclk.
`timescale 1ns/100ps
`default_nettype none
module gen_regs (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Write port
	input wire logic we,
	input wire logic [2:0] widx,
	input wire logic [15:0] wdata,
	// Read port
	input wire logic [2:0] ridx,
	output logic [15:0] rdata
);
	seq_pkg::gen_regs_t s;
	seq_pkg::gen_regs_t next_s;

	always_comb
	begin
		next_s = s;
		if (we)
		begin
			next_s.r[widx] = wdata;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			s <= '0;
		else
			s <= next_s;
	end

	assign rdata = s.r[ridx];
endmodule : gen_regs
`default_nettype wire

// ===== src/aux_store.sv
// Auxiliary byte storage: pair writes, one read port with read-clear.
// Assumes a write and a clearing read never hit the same cycle.
`timescale 1ns/100ps
`default_nettype none
module aux_store (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Pair write, high byte at widx
	input wire logic we,
	input wire logic [6:0] widx,
	input wire logic [15:0] wdata,
	// Read port
	input wire logic [6:0] ridx,
	input wire logic rclr,
	output logic [7:0] rdata
);
	seq_pkg::aux_regs_t s;
	seq_pkg::aux_regs_t next_s;

	always_comb
	begin
		next_s = s;
		if (we)
		begin
			next_s.m[widx] = wdata[15:8];
			next_s.m[7'(widx + 7'h01)] = wdata[7:0];
		end
		// A clearing read (rclr) empties the position
		if (rclr)
		begin
			next_s.m[ridx] = 8'h00;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			s <= '0;
		else
			s <= next_s;
	end

	assign rdata = s.m[ridx];
endmodule : aux_store
`default_nettype wire

// ===== src/ss_decode.sv
// SS format operand decode sequencer with APB control.
// Assumes software loads the instruction, then pulses start.
// Summary of operation
// (RULE1) Compare each operand's high nibble with the storage size limit.
// (RULE2) An operand above the limit halts with stop code 5.
// (RULE3) Save the checked first operand address at aux 40-41.
// (RULE4) Second base high bit set adds a general register to displacement.
// (RULE5) Save the next-instruction address at aux 30-31.
// (RULE6) Read op code from aux 00; upper E or C halts with code 1.
// (RULE7) Upper F goes to decimal decode, upper D to lower decode.
// (RULE8) On F path, second operand below 144 halts with code 4.
// (RULE9) On F path, lower 4 without 8, or 8-4-2 set, halts code 1.
// (RULE10) No 4-bit loads indicator 8; 8 and 4 without 2 loads 0.
// (RULE11) Add second length from aux 01 to form second units address.
// (RULE12) Read aux 07 so it is cleared for execution.
// (RULE13) Indicator without 8-bit starts multiply/divide decimal execution.
// (RULE14) Otherwise add first length to first operand for its units address.
// (RULE15) Decode lower nibble with parity to F1-F9; 0000 parity 1 invalid.
// (RULE16) D path lower 0000 is transfer I/O and skips second protection.
// (RULE17) D path other nibbles halt code 4 if second operand below 144.
// (RULE18) D path halts code 4 if first operand below 144, else decode.
// (RULE19) Base is a 4-bit register address, displacement 12 bits.
// (RULE20) After a halt hold code and address until manual restart.
// (RULE21) Steps run in strict order; execution starts after all checks.
//
// The register addresses and the APB slave port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "ss_consts.svh"
module ss_decode (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Manual restart pin
	input wire logic manual_restart,
	// Execution phase hand-off
	output logic exec_start,
	output logic [7:0] exec_code,
	// Halt indication
	output logic halted,
	output logic [3:0] stop_code_indicator,
	output logic [15:0] fault_address
);
	seq_pkg::seq_regs_t s;
	seq_pkg::seq_regs_t next_s;
	logic aux_we;
	logic [6:0] aux_widx;
	logic [15:0] aux_wdata;
	logic [6:0] aux_ridx;
	logic aux_clr;
	logic [7:0] aux_rd;
	logic idx_we;
	logic [2:0] idx_ridx;
	logic [15:0] idx_rd;
	logic restart;
	logic wr_acc;

	// (RULE19) Base and displacement split
	function automatic logic [15:0] form_addr(input logic [15:0] f,
		input logic [15:0] g);
		if (f[15])
			form_addr = 16'(g + {4'h0, f[11:0]});
		else
			form_addr = f;
	endfunction : form_addr

	// (RULE1) Storage size limit
	function automatic logic addr_ok(input logic [15:0] a,
		input logic [1:0] sz);
		logic [3:0] lim;
		lim = `LIM_16K;
		if (sz == 2'h0)
			lim = `LIM_4K;
		else if (sz == 2'h1)
			lim = `LIM_8K;
		addr_ok = (a[15:12] <= lim);
	endfunction : addr_ok

	function automatic logic protected_addr(input logic [15:0] a);
		protected_addr = (a < `PROT_LIMIT);
	endfunction : protected_addr

	function automatic seq_pkg::seq_regs_t halt_with(
		input seq_pkg::seq_regs_t r, input logic [3:0] c,
		input logic [15:0] a);
		halt_with = r;
		halt_with.st = seq_pkg::st_halt;
		halt_with.stop_code_indicator = c;
		halt_with.fault = a;
	endfunction : halt_with

	function automatic logic mapped(input logic [7:0] a);
		mapped = (a[1:0] == 2'h0) && (a <= `OFF_FAULT);
	endfunction : mapped

	aux_store u_aux (
		.pclk(pclk),
		.presetn(presetn),
		.we(aux_we),
		.widx(aux_widx),
		.wdata(aux_wdata),
		.ridx(aux_ridx),
		.rclr(aux_clr),
		.rdata(aux_rd)
	);

	gen_regs u_idx (
		.pclk(pclk),
		.presetn(presetn),
		.we(idx_we),
		.widx(pwdata[`GRWR_IDX_HI:`GRWR_IDX_LO]),
		.wdata(pwdata[15:0]),
		.ridx(idx_ridx),
		.rdata(idx_rd)
	);

	assign wr_acc = psel && penable && pwrite;
	// The second and third flops of the synchroniser feed the edge detect
	assign restart = s.rsync[1] && !s.rsync[2];
	assign idx_we = wr_acc && (paddr == `OFF_GRWR);
	assign idx_ridx = (s.st == seq_pkg::st_op1) ? s.first_field[14:12]
		: s.second_field[14:12];

	always_comb
	begin
		logic [3:0] l;
		logic par;
		l = s.high_nibble_register;
		par = ~^s.lower_nibble_latch;
		next_s = s;
		next_s.start = 1'b0;
		next_s.rsync = {s.rsync[1:0], manual_restart};
		aux_we = 1'b0;
		aux_widx = `AUX_OP;
		aux_wdata = {s.op, s.byte2};
		aux_ridx = `AUX_OP;
		aux_clr = 1'b0;
		if (psel && !penable)
		begin
			next_s.rdata = 32'h0000_0000;
			if (paddr == `OFF_CTRL)
				next_s.rdata = {29'h0, s.size, 1'b0};
			else if (paddr == `OFF_INSTR)
				next_s.rdata = {s.iaddr, s.byte2, s.op};
			else if (paddr == `OFF_FIELDS)
				next_s.rdata = {s.second_field, s.first_field};
			else if (paddr == `OFF_STATUS)
				next_s.rdata = {12'h0, s.high_nibble_register, s.exec_code,
					s.stop_code_indicator, 2'h0,
					s.st == seq_pkg::st_halt, s.st != seq_pkg::st_idle};
			else if (paddr == `OFF_OP1)
				next_s.rdata = {s.units1, s.addr1};
			else if (paddr == `OFF_OP2)
				next_s.rdata = {s.units2, s.addr2};
			else if (paddr == `OFF_FAULT)
				next_s.rdata = {16'h0, s.fault};
		end
		// Loading is refused while a sequence runs
		if (wr_acc && s.st == seq_pkg::st_idle)
		begin
			if (paddr == `OFF_CTRL)
			begin
				next_s.start = pwdata[`CTRL_START];
				next_s.size = pwdata[`CTRL_SIZE_HI:`CTRL_SIZE_LO];
			end
			else if (paddr == `OFF_INSTR)
			begin
				next_s.op = pwdata[7:0];
				next_s.byte2 = pwdata[15:8];
				next_s.iaddr = pwdata[31:16];
			end
			else if (paddr == `OFF_FIELDS)
			begin
				next_s.first_field = pwdata[15:0];
				next_s.second_field = pwdata[31:16];
			end
		end
		// (RULE21) One step per state, strictly ordered
		case (s.st)
			seq_pkg::st_idle:
				if (s.start)
				begin
					aux_we = 1'b1;
					next_s.st = seq_pkg::st_op1;
				end
			seq_pkg::st_op1:
			begin
				next_s.addr1 = form_addr(s.first_field, idx_rd);
				next_s.st = seq_pkg::st_chk1;
			end
			seq_pkg::st_chk1:
				// (RULE2) Address error stop
				if (!addr_ok(s.addr1, s.size))
					next_s = halt_with(next_s, `STOP_ADDRESS, s.addr1);
				else
				begin
					// (RULE3) Save first operand
					aux_we = 1'b1;
					aux_widx = `AUX_OP1;
					aux_wdata = s.addr1;
					next_s.st = seq_pkg::st_op2;
				end
			seq_pkg::st_op2:
			begin
				// (RULE4) Optional indexing
				next_s.addr2 = form_addr(s.second_field, idx_rd);
				next_s.st = seq_pkg::st_chk2;
			end
			seq_pkg::st_chk2:
				if (!addr_ok(s.addr2, s.size))
					next_s = halt_with(next_s, `STOP_ADDRESS, s.addr2);
				else
				begin
					// (RULE5) Save next-instruction address
					aux_we = 1'b1;
					aux_widx = `AUX_NEXT;
					aux_wdata = 16'(s.iaddr + `INSTR_LEN);
					next_s.st = seq_pkg::st_oprd;
				end
			seq_pkg::st_oprd:
			begin
				next_s.upper_nibble_latch = aux_rd[7:4];
				next_s.lower_nibble_latch = aux_rd[3:0];
				next_s.high_nibble_register = aux_rd[3:0];
				next_s.st = seq_pkg::st_udec;
			end
			seq_pkg::st_udec:
				// (RULE7) Route on upper nibble
				if (s.upper_nibble_latch == `UP_DEC)
					next_s.st = seq_pkg::st_fprot;
				else if (s.upper_nibble_latch == `UP_LOW)
					next_s.st = seq_pkg::st_dtio;
				else
					// (RULE6) Invalid upper nibble
					next_s = halt_with(next_s, `STOP_OPCODE, s.addr2);
			seq_pkg::st_fprot:
				// (RULE8) Protected second operand
				if (protected_addr(s.addr2))
					next_s = halt_with(next_s, `STOP_PROTECT, s.addr2);
				else
					next_s.st = seq_pkg::st_flow;
			seq_pkg::st_flow:
				// (RULE9) Invalid lower nibble
				if ((l[2] && !l[3]) || (l[3] && l[2] && l[1]))
					next_s = halt_with(next_s, `STOP_OPCODE, s.addr2);
				else
				begin
					// (RULE10) Indicator load
					next_s.high_nibble_register = l[2] ? `IND_MULDIV
						: `IND_LENGTHS;
					next_s.st = seq_pkg::st_len2;
				end
			seq_pkg::st_len2:
			begin
				// (RULE11) Second units address
				aux_ridx = `AUX_BYTE2;
				next_s.units2 = 16'(s.addr2 + {12'h0, aux_rd[3:0]});
				next_s.st = seq_pkg::st_clr;
			end
			seq_pkg::st_clr:
			begin
				// (RULE12) Clearing read
				aux_ridx = `AUX_SCRATCH;
				aux_clr = 1'b1;
				next_s.st = seq_pkg::st_md;
			end
			seq_pkg::st_md:
				// (RULE13) Multiply or divide decimal
				if (!l[3])
				begin
					next_s.exec_code = {s.upper_nibble_latch,
						s.lower_nibble_latch};
					next_s.st = seq_pkg::st_exec;
				end
				else
					next_s.st = seq_pkg::st_len1;
			seq_pkg::st_len1:
			begin
				// (RULE14) First units address
				aux_ridx = `AUX_BYTE2;
				next_s.units1 = 16'(s.addr1 + {12'h0, aux_rd[7:4]});
				next_s.st = seq_pkg::st_ffin;
			end
			seq_pkg::st_ffin:
				// (RULE15) Final decimal-class decode
				if (({par, s.lower_nibble_latch} != 5'h10)
					&& (s.lower_nibble_latch <= 4'h9)
					&& (s.lower_nibble_latch != 4'h0))
				begin
					next_s.exec_code = aux_rd;
					next_s.st = seq_pkg::st_exec;
				end
				else
					next_s = halt_with(next_s, `STOP_OPCODE, s.addr2);
			seq_pkg::st_dtio:
				// (RULE16) Transfer I/O skips the check
				if (l == 4'h0)
					next_s.st = seq_pkg::st_dp1;
				else
					next_s.st = seq_pkg::st_dp2;
			seq_pkg::st_dp2:
				// (RULE17) Protected second operand
				if (protected_addr(s.addr2))
					next_s = halt_with(next_s, `STOP_PROTECT, s.addr2);
				else
					next_s.st = seq_pkg::st_dp1;
			seq_pkg::st_dp1:
				// (RULE18) Protected first operand
				if (protected_addr(s.addr1))
					next_s = halt_with(next_s, `STOP_PROTECT, s.addr1);
				else
					next_s.st = seq_pkg::st_dfin;
			seq_pkg::st_dfin:
				if (l <= 4'h2)
				begin
					next_s.exec_code = {s.upper_nibble_latch, l};
					next_s.st = seq_pkg::st_exec;
				end
				else
					next_s = halt_with(next_s, `STOP_OPCODE, s.addr2);
			seq_pkg::st_exec:
				next_s.st = seq_pkg::st_idle;
			seq_pkg::st_halt:
				// (RULE20) Wait for manual restart
				if (restart)
				begin
					next_s.stop_code_indicator = 4'h0;
					next_s.st = seq_pkg::st_idle;
				end
			default:
				next_s.st = seq_pkg::st_idle;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s <= '0;
			s.st <= seq_pkg::st_idle;
			s.size <= `SIZE_RST;
			s.iaddr <= `IADDR_RST;
		end
		else
			s <= next_s;
	end

	assign prdata = s.rdata;
	// Zero wait states keep the master simple
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped(paddr);
	assign exec_start = (s.st == seq_pkg::st_exec);
	assign exec_code = s.exec_code;
	assign halted = (s.st == seq_pkg::st_halt);
	assign stop_code_indicator = s.stop_code_indicator;
	assign fault_address = s.fault;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	chk_addr_limit: assert property ( // RULE2
		s.st == seq_pkg::st_chk1 && s.addr1[15:12] > `LIM_16K
		|=> halted && stop_code_indicator == `STOP_ADDRESS
		&& fault_address == $past(s.addr1))
		else $error("operand above limit did not stop with code 5");
	chk_first_saved: assert property ( // RULE3
		s.st == seq_pkg::st_chk1 && addr_ok(s.addr1, s.size)
		|-> aux_we && aux_widx == `AUX_OP1 ##1 s.st == seq_pkg::st_op2)
		else $error("first operand not saved");
	chk_index_add: assert property ( // RULE4
		s.st == seq_pkg::st_op2 && s.second_field[15]
		|=> s.addr2 == 16'($past(idx_rd) + {4'h0,
		$past(s.second_field[11:0])}))
		else $error("indexed second address wrong");
	chk_bad_upper: assert property ( // RULE6
		s.st == seq_pkg::st_udec && (s.upper_nibble_latch == `UP_BAD_E
		|| s.upper_nibble_latch == `UP_BAD_C)
		|=> halted && stop_code_indicator == `STOP_OPCODE)
		else $error("invalid upper nibble not stopped");
	chk_dec_protect: assert property ( // RULE8
		s.st == seq_pkg::st_fprot && s.addr2 < `PROT_LIMIT
		|=> halted && stop_code_indicator == `STOP_PROTECT)
		else $error("protected second operand not stopped");
	chk_units_two: assert property ( // RULE11
		s.st == seq_pkg::st_len2
		|=> s.units2 == 16'($past(s.addr2) + {12'h0, $past(aux_rd[3:0])}))
		else $error("second units address wrong");
	chk_muldiv_go: assert property ( // RULE13
		s.st == seq_pkg::st_flow && s.high_nibble_register[3:1] == 3'h6
		|=> ##3 exec_start)
		else $error("multiply/divide decimal not started");
	chk_halt_hold: assert property ( // RULE20
		halted && !restart |=> halted && $stable(stop_code_indicator)
		&& $stable(fault_address))
		else $error("halt state not held");
	chk_tio_skip: assert property ( // RULE16
		s.st == seq_pkg::st_dtio && s.high_nibble_register == 4'h0
		|=> s.st == seq_pkg::st_dp1)
		else $error("transfer I/O did not skip check");
	chk_next_saved: assert property ( // RULE5
		s.st == seq_pkg::st_chk2 && addr_ok(s.addr2, s.size)
		|-> aux_we && aux_widx == `AUX_NEXT
		&& aux_wdata == 16'(s.iaddr + `INSTR_LEN))
		else $error("next-instruction address not saved");
	chk_scratch_clear: assert property ( // RULE12
		s.st == seq_pkg::st_clr |-> aux_clr && aux_ridx == `AUX_SCRATCH)
		else $error("scratch position not cleared");
endmodule : ss_decode
`default_nettype wire

// ===== bench/storage_image.sv
// Image of the general registers that operand address fields index.
// Assumes the bench mirrors every general register write it sends.
`timescale 1ns/100ps
`default_nettype none
module storage_image (
	// Clock
	input wire logic pclk,
	// Register image write
	input wire logic we,
	input wire logic [2:0] widx,
	input wire logic [15:0] wdata,
	// Address fields in, effective addresses out
	input wire logic [15:0] f1,
	input wire logic [15:0] f2,
	output logic [15:0] e1,
	output logic [15:0] e2
);
	logic [15:0] img [8];

	always_ff @(posedge pclk)
	begin
		if (we)
			img[widx] <= wdata;
	end

	function automatic logic [15:0] eff(input logic [15:0] f);
		return f[15] ? img[f[14:12]] + {4'h0, f[11:0]} : f;
	endfunction : eff

	assign e1 = eff(f1);
	assign e2 = eff(f2);
endmodule : storage_image
`default_nettype wire

// ===== bench/ss_format_operand_decode_bench.sv
// Self-checking bench for the SS operand decode sequencer.
// Assumes APB with zero wait states and the storage image beside it.
`timescale 1ns/100ps
`default_nettype none
`include "ss_consts.svh"
module ss_format_operand_decode_bench;
	logic pclk, presetn, psel, penable, pwrite, manual_restart;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rv, r2;
	logic pready, pslverr, exec_start, halted, ev, bad;
	logic [7:0] exec_code;
	logic [3:0] stop_code_indicator, lo, lim;
	logic [15:0] fault_address, im_wdata, im_f1, im_f2, e1, e2;
	logic im_we;
	logic [2:0] im_widx;
	int n_fail = 0;
	int checks = 0;
	int n_exec = 0;

	ss_decode uut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .manual_restart(manual_restart),
		.exec_start(exec_start), .exec_code(exec_code),
		.halted(halted), .stop_code_indicator(stop_code_indicator),
		.fault_address(fault_address));
	storage_image im (.pclk(pclk), .we(im_we), .widx(im_widx),
		.wdata(im_wdata), .f1(im_f1), .f2(im_f2), .e1(e1), .e2(e2));

	initial
	begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end

	// Counting pulses lets a missed or doubled start show up
	always @(posedge pclk)
		if (exec_start === 1'b1)
			n_exec <= n_exec + 1;

	task automatic chk(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("FAIL %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic close_out();
		$display("checks %0d mismatches %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : close_out

	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		chk("pready", 32'(pready), 32'h1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic setgr(input logic [2:0] i, input logic [15:0] v);
		@(posedge pclk);
		im_we <= 1'b1;
		im_widx <= i;
		im_wdata <= v;
		apb(1'b1, `OFF_GRWR, {13'h0000, i, v}, rv, ev);
		im_we <= 1'b0;
	endtask : setgr

	task automatic run(input logic [1:0] sz, input logic [15:0] f1,
		input logic [15:0] f2, input logic [7:0] op,
		input logic [3:0] stop, input logic [15:0] x);
		int n0;
		int k;
		logic [15:0] a1;
		logic [15:0] a2;
		im_f1 = f1;
		im_f2 = f2;
		#1;
		a1 = e1;
		a2 = e2;
		apb(1'b1, `OFF_FIELDS, {f2, f1}, rv, ev);
		apb(1'b1, `OFF_INSTR, {16'h0400, 8'h35, op}, rv, ev);
		n0 = n_exec;
		apb(1'b1, `OFF_CTRL, {29'h0, sz, 1'b1}, rv, ev);
		k = 0;
		while (halted !== 1'b1 && n_exec == n0 && k < 40)
			@(posedge pclk) k += 1;
		#1;
		chk("one outcome", 32'(halted) + 32'(n_exec - n0), 1);
		chk("halted", 32'(halted), 32'(stop != 4'h0));
		if (stop != 4'h0)
		begin
			chk("stop code", 32'(stop_code_indicator), 32'(stop));
			chk("fault", 32'(fault_address), 32'(x));
			repeat (20) @(posedge pclk);
			apb(1'b1, `OFF_CTRL, 32'h0000_0005, rv, ev);
			apb(1'b0, `OFF_STATUS, 32'h0, rv, ev);
			chk("held", {rv[7:4], rv[1], fault_address}, {stop, 1'b1, x});
			@(posedge pclk);
			manual_restart <= 1'b1;
			repeat (2) @(posedge pclk);
			manual_restart <= 1'b0;
			k = 0;
			while (halted === 1'b1 && k < 10)
				@(posedge pclk) k += 1;
			#1;
			chk("restart", 32'({halted, stop_code_indicator}), 0);
		end
		else
		begin
			chk("exec code", 32'(exec_code), 32'(x));
			apb(1'b0, `OFF_OP2, 32'h0, r2, ev);
			chk("op2 addr", 32'(r2[15:0]), 32'(a2));
			apb(1'b0, `OFF_OP1, 32'h0, rv, ev);
			chk("op1 addr", 32'(rv[15:0]), 32'(a1));
			if (op[7:4] == `UP_DEC)
			begin
				chk("units2", 32'(r2[31:16]), 32'(a2 + 16'h5));
				if (op[3:2] != 2'b11)
					chk("units1", 32'(rv[31:16]), 32'(a1 + 16'h3));
				apb(1'b0, `OFF_STATUS, 32'h0, rv, ev);
				chk("indicator", 32'(rv[19:16]),
					op[3:2] == 2'b11 ? 32'h0 : 32'h8);
			end
		end
		$display("case op %h sizes %0d stop %h done", op, sz, stop);
	endtask : run

	initial
	begin
		#400000;
		n_fail++;
		close_out();
	end

	initial
	begin
		{presetn, psel, penable, pwrite, manual_restart, im_we} = 6'h00;
		{paddr, pwdata, im_widx, im_wdata, im_f1, im_f2} = 91'h0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, `OFF_STATUS, 32'h0, rv, ev);
		chk("status reset", rv, 32'h0);
		chk("ports reset", 32'({halted, stop_code_indicator}), 32'h0);
		apb(1'b0, 8'h20, 32'h0, rv, ev);
		chk("unmapped", {ev, rv[30:0]}, 32'h8000_0000);
		apb(1'b0, `OFF_GRWR, 32'h0, rv, ev);
		chk("grwr read", rv, 32'h0);
		$display("reset and map test done");
		setgr(3'd3, 16'h0100);
		setgr(3'd5, 16'h2FF0);
		for (int s = 0; s < 4; s++)
		begin
			lim = s == 0 ? 4'h0 : (s == 1 ? 4'h1 : 4'h2);
			run(2'(s), {lim, 12'hFFF}, 16'h0300, 8'hF1, 4'h0, 16'h00F1);
			run(2'(s), {lim + 4'h1, 12'h0}, 16'h0300, 8'hF1, `STOP_ADDRESS,
				{lim + 4'h1, 12'h0});
			run(2'(s), 16'h0300, {lim + 4'h1, 12'h0}, 8'hF1, `STOP_ADDRESS,
				{lim + 4'h1, 12'h0});
		end
		for (int i = 0; i < 16; i++)
		begin
			lo = 4'(i);
			bad = lo == 4'h0 || lo == 4'hA || lo == 4'hB
				|| (lo[2] && !lo[3]) || lo[3:1] == 3'b111;
			run(2'd2, 16'h0200, 16'h0300, {4'hF, lo}, bad ? 4'h1 : 4'h0,
				bad ? 16'h0300 : {8'h00, 4'hF, lo});
			run(2'd2, 16'h0200, 16'h0300, {4'hD, lo}, lo > 4'h2 ? 4'h1 : 4'h0,
				lo > 4'h2 ? 16'h0300 : {8'h00, 4'hD, lo});
			if (lo != 4'hD && lo != 4'hF)
				run(2'd2, 16'h0200, 16'h0300, {lo, 4'h1}, 4'h1, 16'h0300);
		end
		run(2'd2, 16'h0200, 16'h008F, 8'hF1, 4'h4, 16'h008F);
		run(2'd2, 16'h0010, 16'h0090, 8'hF1, 4'h0, 16'h00F1);
		run(2'd2, 16'h0200, 16'h008F, 8'hF4, 4'h4, 16'h008F);
		run(2'd2, 16'h0200, 16'h3000, 8'hE1, 4'h5, 16'h3000);
		run(2'd2, 16'h0200, 16'h0010, 8'hD0, 4'h0, 16'h00D0);
		run(2'd2, 16'h0200, 16'h008F, 8'hD1, 4'h4, 16'h008F);
		run(2'd2, 16'h0200, 16'h0090, 8'hD2, 4'h0, 16'h00D2);
		run(2'd2, 16'h008F, 16'h0200, 8'hD1, 4'h4, 16'h008F);
		run(2'd2, 16'h0090, 16'h0200, 8'hD1, 4'h0, 16'h00D1);
		run(2'd2, 16'h008F, 16'h0010, 8'hD0, 4'h4, 16'h008F);
		run(2'd2, 16'h0200, 16'hB020, 8'hF1, 4'h0, 16'h00F1);
		run(2'd2, 16'h0200, 16'hBFFF, 8'hF2, 4'h0, 16'h00F2);
		run(2'd2, 16'hD020, 16'h0300, 8'hF1, 4'h5, 16'h3010);
		close_out();
	end
endmodule : ss_format_operand_decode_bench
`default_nettype wire
